// *** logic/plt_lane.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// One lane: training hold, power state and user pattern preamble
module plt_lane (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lane controls
    input wire logic disable_lane,
    input wire logic quiet,
    input wire logic rate_sel,
    input wire logic bypass_align,
    input wire logic pattern_en,
    // Link side
    input wire logic partner_seen,
    input wire logic align_seen,
    input wire logic [7:0] user_sym,
    // Outputs
    output logic [1:0] link_state,
    output logic rx_detect_en,
    output logic rx_term_en,
    output logic [1:0] pwr_state,
    output logic eios_send,
    output logic rate_5g,
    output logic [7:0] tx_sym,
    output logic tx_valid
);
    plt_pkg::plt_link_e ls_ff, nxt_ls;
    plt_pkg::plt_pat_e ps_ff, nxt_ps;
    logic [1:0] idx_ff, nxt_idx;
    logic hold;
    logic [7:0] align_sym;
    logic [7:0] sync_sym;

    assign hold = disable_lane | quiet;

    // Lane training: held lanes drop straight to quiet, no EIOS, never Disabled
    always_comb
    begin
        nxt_ls = ls_ff;
        case (ls_ff)
            plt_pkg::LS_QUIET:
                if (!hold)
                    nxt_ls = plt_pkg::LS_DETECT;
            plt_pkg::LS_DETECT:
                if (hold)
                    nxt_ls = plt_pkg::LS_QUIET;
                else if (partner_seen)
                    nxt_ls = plt_pkg::LS_UP;
            plt_pkg::LS_UP:
                if (hold)
                    nxt_ls = plt_pkg::LS_QUIET;
            default:
                nxt_ls = plt_pkg::LS_QUIET;
        endcase
    end

    // Pattern symbols by position
    always_comb
    begin
        case (idx_ff)
            2'h0: align_sym = plt_pkg::SYM_D3_2;
            2'h1: align_sym = plt_pkg::SYM_D18_2;
            2'h2: align_sym = plt_pkg::SYM_D13_2;
            default: align_sym = plt_pkg::SYM_D17_1;
        endcase
        case (idx_ff)
            2'h0: sync_sym = plt_pkg::SYM_K28_5;
            2'h1: sync_sym = plt_pkg::SYM_D3_2;
            2'h2: sync_sym = plt_pkg::SYM_D18_2;
            default: sync_sym = plt_pkg::SYM_D13_2;
        endcase
    end

    // Preamble sequencer: alignment then sync then user pattern
    always_comb
    begin
        nxt_ps = ps_ff;
        nxt_idx = idx_ff + 2'h1;
        if (!pattern_en)
        begin
            nxt_ps = plt_pkg::PS_IDLE;
            nxt_idx = 2'h0;
        end
        else
        begin
            case (ps_ff)
                plt_pkg::PS_IDLE:
                begin
                    nxt_ps = plt_pkg::PS_ALIGN;
                    nxt_idx = 2'h0;
                end
                plt_pkg::PS_ALIGN:
                    if (idx_ff == 2'h3 && (bypass_align || align_seen))
                        nxt_ps = plt_pkg::PS_SYNC;
                plt_pkg::PS_SYNC:
                    if (idx_ff == 2'h3)
                        nxt_ps = plt_pkg::PS_USER;
                plt_pkg::PS_USER:
                    nxt_idx = 2'h0;
                default:
                    nxt_ps = plt_pkg::PS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ls_ff <= plt_pkg::LS_QUIET;
            ps_ff <= plt_pkg::PS_IDLE;
            idx_ff <= 2'h0;
            link_state <= 2'h0;
            rx_detect_en <= 1'b0;
            rx_term_en <= 1'b0;
            pwr_state <= plt_pkg::PWR_P1;
            eios_send <= 1'b0;
            rate_5g <= 1'b0;
            tx_sym <= 8'h00;
            tx_valid <= 1'b0;
        end
        else
        begin
            ls_ff <= nxt_ls;
            ps_ff <= nxt_ps;
            idx_ff <= nxt_idx;
            link_state <= nxt_ls;
            rx_detect_en <= !hold && nxt_ls == plt_pkg::LS_DETECT;
            rx_term_en <= quiet && !disable_lane;
            pwr_state <= (disable_lane || !quiet && nxt_ls == plt_pkg::LS_QUIET) ?
                plt_pkg::PWR_P1 : plt_pkg::PWR_P0;
            eios_send <= 1'b0;
            rate_5g <= rate_sel & quiet;
            tx_valid <= pattern_en && ps_ff != plt_pkg::PS_IDLE;
            case (ps_ff)
                plt_pkg::PS_ALIGN: tx_sym <= align_sym;
                plt_pkg::PS_SYNC: tx_sym <= sync_sym;
                plt_pkg::PS_USER: tx_sym <= user_sym;
                default: tx_sym <= 8'h00;
            endcase
        end
    end
endmodule

// *** logic/plt_phy_ctrl.sv ***
`timescale 1ns/1ps
//Contract
// - SKIP ordered-sets spaced by 12-bit interval; zero interval sends none.
// - Disable bit holds lane training in Detect.Quiet until cleared.
// - Disabled lane never enters the Disabled training state.
// - Disabled idle lane stops receiver detection.
// - Disabled live link drops to Detect.Quiet with no EIOS.
// - Disabled lane serdes held in P1.
// - Disable bits 18 and 19 act on their own lanes.
// - Quiet bits 20, 22, 23 hold lane in Detect.Quiet.
// - Quiet lane in Detect.Quiet enables termination, transmitters in P0.
// - Quiet lane can send test patterns without partner or loopback.
// - Rate bit picks 5.0 GT/s only while quiet bit set.
// - Without bypass, repeat alignment until checker sees it, then sync.
// - With bypass, one alignment, one sync, then user pattern.
module plt_phy_ctrl #(
    parameter int LANES = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Serial EEPROM preload
    input wire logic ee_load,
    input wire logic [31:0] ee_data,
    // Symbol timing
    input wire logic sym_tick,
    output logic skip_req,
    // Per-lane link side
    input wire logic [LANES-1:0] partner_seen,
    input wire logic [LANES-1:0] align_seen,
    input wire logic [LANES-1:0] pattern_en,
    input wire logic [8*LANES-1:0] user_sym,
    // Per-lane outputs
    output logic [2*LANES-1:0] link_state,
    output logic [LANES-1:0] rx_detect_en,
    output logic [LANES-1:0] rx_term_en,
    output logic [2*LANES-1:0] pwr_state,
    output logic [LANES-1:0] eios_send,
    output logic [LANES-1:0] rate_5g,
    output logic [8*LANES-1:0] tx_sym,
    output logic [LANES-1:0] tx_valid
);
    ////////////////////////////////////////////////////////////////////////////
    logic rs1_ff;
    logic rs2_ff;
    logic rst_n;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rs1_ff <= 1'b0;
            rs2_ff <= 1'b0;
        end
        else
        begin
            rs1_ff <= 1'b1;
            rs2_ff <= rs1_ff;
        end
    end
    assign rst_n = rs2_ff;

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] status;
    logic skip_ff;
    logic skip_raw;

    // Control register: EEPROM preload then software writes
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        if (ee_load)
            nxt_ctrl = ee_data & plt_pkg::CTRL_WMASK;
        if (wr && addr == plt_pkg::REG_CTRL_OFS)
            nxt_ctrl = wdata & plt_pkg::CTRL_WMASK;
    end

    // Read mux; unmapped reads return zero
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (rd)
        begin
            if (addr == plt_pkg::REG_CTRL_OFS)
                nxt_rdata = ctrl_ff;
            else if (addr == plt_pkg::REG_STAT_OFS)
                nxt_rdata = status;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= plt_pkg::CTRL_RESET;
            rdata_ff <= 32'h00000000;
            skip_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
            skip_ff <= skip_raw;
        end
    end
    assign rdata = rdata_ff;
    assign skip_req = skip_ff;

    ////////////////////////////////////////////////////////////////////////////
    // SKIP pacing
    plt_skip_timer #(
        .W(plt_pkg::SKIP_W)
    ) u_skip (
        .clk(clk),
        .rst_n(rst_n),
        .sym_tick(sym_tick),
        .interval(ctrl_ff[plt_pkg::SKIP_LSB +: plt_pkg::SKIP_W]),
        .skip_req(skip_raw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lane bit offsets within each control nibble
    localparam logic [5:0] LANE_BITS = {plt_pkg::LANE2_BIT, plt_pkg::LANE1_BIT,
        plt_pkg::LANE0_BIT};

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : g_lane
            localparam int B = int'(LANE_BITS[2*g +: 2]);
            plt_lane u_lane (
                .clk(clk),
                .rst_n(rst_n),
                .disable_lane(ctrl_ff[plt_pkg::DIS_LSB + B]),
                .quiet(ctrl_ff[plt_pkg::QUIET_LSB + B]),
                .rate_sel(ctrl_ff[plt_pkg::RATE_LSB + B]),
                .bypass_align(ctrl_ff[plt_pkg::BYP_LSB + B]),
                .pattern_en(pattern_en[g]),
                .partner_seen(partner_seen[g]),
                .align_seen(align_seen[g]),
                .user_sym(user_sym[8*g +: 8]),
                .link_state(link_state[2*g +: 2]),
                .rx_detect_en(rx_detect_en[g]),
                .rx_term_en(rx_term_en[g]),
                .pwr_state(pwr_state[2*g +: 2]),
                .eios_send(eios_send[g]),
                .rate_5g(rate_5g[g]),
                .tx_sym(tx_sym[8*g +: 8]),
                .tx_valid(tx_valid[g])
            );
            // Status: lane link state, power state and the detect, termination, rate and valid flags
            assign status[8*g +: 2] = link_state[2*g +: 2];
            assign status[8*g+2 +: 2] = pwr_state[2*g +: 2];
            assign status[8*g+4 +: 4] = {tx_valid[g], rate_5g[g], rx_term_en[g],
                rx_detect_en[g]};
        end
    endgenerate
    assign status[31:8*LANES] = '0;
endmodule

// *** logic/plt_pkg.sv ***
package plt_pkg;
    // Register map
    localparam logic [11:0] REG_CTRL_OFS = 12'h234;
    localparam logic [11:0] REG_STAT_OFS = 12'h240;
    localparam logic [31:0] CTRL_RESET = 32'h0000049C;
    localparam logic [31:0] CTRL_WMASK = 32'hDDDD0FFF;
    // Field positions
    localparam int SKIP_LSB = 0;
    localparam int SKIP_W = 12;
    localparam int DIS_LSB = 16;
    localparam int QUIET_LSB = 20;
    localparam int RATE_LSB = 24;
    localparam int BYP_LSB = 28;
    localparam logic [11:0] SKIP_MIN = 12'h49C;
    localparam logic [11:0] SKIP_MAX = 12'h602;
    // Lane index to bit offset within each nibble (lanes at 0, 2, 3)
    localparam logic [1:0] LANE0_BIT = 2'h0;
    localparam logic [1:0] LANE1_BIT = 2'h2;
    localparam logic [1:0] LANE2_BIT = 2'h3;
    // Power states
    localparam logic [1:0] PWR_P0 = 2'h0;
    localparam logic [1:0] PWR_P1 = 2'h1;
    // Symbol codes
    localparam logic [7:0] SYM_D3_2 = 8'h43;
    localparam logic [7:0] SYM_D18_2 = 8'h52;
    localparam logic [7:0] SYM_D13_2 = 8'h4D;
    localparam logic [7:0] SYM_D17_1 = 8'h31;
    localparam logic [7:0] SYM_K28_5 = 8'hBC;
    // Pattern sequencer states
    typedef enum logic [2:0] {
        PS_IDLE, PS_ALIGN, PS_SYNC, PS_USER
    } plt_pat_e;
    // Link states of the lane model
    typedef enum logic [1:0] {
        LS_QUIET, LS_DETECT, LS_UP
    } plt_link_e;
endpackage

// *** logic/plt_skip_timer.sv ***
`timescale 1ns/1ps
// Paces SKIP ordered-sets by a programmed symbol-time interval
module plt_skip_timer #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic sym_tick,
    input wire logic [W-1:0] interval,
    // Request
    output logic skip_req
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic req_ff;
    logic nxt_req;

    // Count symbol times; zero interval stops all requests
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_req = 1'b0;
        if (interval == '0)
        begin
            nxt_cnt = '0;
        end
        else if (sym_tick)
        begin
            if (cnt_ff + W'(1) >= interval)
            begin
                nxt_cnt = '0;
                nxt_req = 1'b1;
            end
            else
            begin
                nxt_cnt = cnt_ff + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            req_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            req_ff <= nxt_req;
        end
    end

    assign skip_req = req_ff;
endmodule

// *** tb/plt_phy_ctrl_monitor.sv ***
`timescale 1ns/1ps
module plt_phy_ctrl_monitor #(
    parameter int LANES = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic ee_load,
    input wire logic [31:0] ee_data,
    // Lane outputs
    input wire logic skip_req,
    input wire logic [2*LANES-1:0] link_state,
    input wire logic [LANES-1:0] rx_detect_en,
    input wire logic [LANES-1:0] rx_term_en,
    input wire logic [2*LANES-1:0] pwr_state,
    input wire logic [LANES-1:0] eios_send,
    input wire logic [LANES-1:0] rate_5g,
    input wire logic [LANES-1:0] tx_valid
);
    logic [31:0] sh_ff;
    logic [31:0] nxt_sh;
    logic [2:0] zc_ff;
    logic [2:0] nxt_zc;
    // Shadow of the control word and count of cycles with a zero interval
    always_comb
    begin
        nxt_sh = sh_ff;
        if (ee_load)
            nxt_sh = ee_data & plt_pkg::CTRL_WMASK;
        if (wr && addr == plt_pkg::REG_CTRL_OFS)
            nxt_sh = wdata & plt_pkg::CTRL_WMASK;
        nxt_zc = (sh_ff[11:0] != 12'h000) ? 3'h0 : (zc_ff == 3'h7) ? 3'h7 : zc_ff + 3'h1;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_ff <= plt_pkg::CTRL_RESET;
            zc_ff <= 3'h0;
        end
        else
        begin
            sh_ff <= nxt_sh;
            zc_ff <= nxt_zc;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_ctrl_read: assert property ($past(rd) && $past(addr) == plt_pkg::REG_CTRL_OFS
        |-> rdata == $past(sh_ff)) else $error("control readback wrong");
    a_no_eios: assert property (eios_send == '0) else $error("idle set sent");
    a_skip_off: assert property (zc_ff == 3'h7 |-> !skip_req)
        else $error("skip sent with zero interval");
    // Per-lane holds; lanes sit at bit 0, 2 and 3 of each nibble
    for (genvar i = 0; i < LANES; i++)
    begin : g_ln
        localparam int B = (i == 0) ? 0 : i + 1;
        logic dis;
        logic qt;
        logic rt;
        assign dis = sh_ff[plt_pkg::DIS_LSB+B];
        assign qt = sh_ff[plt_pkg::QUIET_LSB+B];
        assign rt = sh_ff[plt_pkg::RATE_LSB+B];
        a_dis_hold: assert property (dis && $past(dis)
            |-> link_state[2*i+:2] == 2'h0 && pwr_state[2*i+:2] == plt_pkg::PWR_P1
            && !rx_detect_en[i]) else $error("disable hold");
        a_quiet_hold: assert property (qt && $past(qt)
            && $past(link_state[2*i+:2]) == 2'h0 |-> link_state[2*i+:2] == 2'h0)
            else $error("quiet lane left quiet");
        a_quiet_p0: assert property (qt && !dis && $past(qt && !dis)
            && link_state[2*i+:2] == 2'h0
            |-> rx_term_en[i] && pwr_state[2*i+:2] == plt_pkg::PWR_P0)
            else $error("quiet power");
        a_rate_sel: assert property ($stable(sh_ff) |-> rate_5g[i] == (rt && qt))
            else $error("rate select wrong");
    end
    c_skip: cover property (skip_req);
    c_txv: cover property (tx_valid[0]);
    c_up: cover property (link_state[1:0] == 2'h2);
endmodule
bind plt_phy_ctrl plt_phy_ctrl_monitor #(.LANES(LANES)) u_mon (.clk, .rstn, .addr, .wdata,
    .wr, .rd, .rdata, .ee_load, .ee_data, .skip_req, .link_state, .rx_detect_en, .rx_term_en,
    .pwr_state, .eios_send, .rate_5g, .tx_valid);

// *** tb/plt_phy_ctrl_tb.sv ***
`timescale 1ns/1ps
module plt_phy_ctrl_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ee_load = 1'b0;
    logic [31:0] ee_data = 32'h0;
    logic sym_tick = 1'b0;
    logic [2:0] partner_seen = 3'h0;
    logic [2:0] align_seen = 3'h0;
    logic [2:0] pattern_en = 3'h0;
    logic [23:0] user_sym = 24'h0;
    logic [31:0] rdata;
    logic skip_req;
    logic [5:0] link_state, pwr_state;
    logic [2:0] rx_detect_en, rx_term_en, eios_send, rate_5g, tx_valid;
    logic [23:0] tx_sym;
    int num_errors = 0;
    int comparisons = 0;
    // Device under test
    plt_phy_ctrl uut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .ee_load, .ee_data,
        .sym_tick, .skip_req, .partner_seen, .align_seen, .pattern_en, .user_sym, .link_state,
        .rx_detect_en, .rx_term_en, .pwr_state, .eios_send, .rate_5g, .tx_sym, .tx_valid);
    // 10 MHz clock
    initial
    begin
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One clock, then let the edge's updates land
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // Bounded wait on a lane's state; a hang ends the run
    task automatic wait_lane(input int ln, input bit up, input bit sync);
        int k;
        for (k = 0; k < 200; k++)
        begin
            step();
            if (up && link_state[2*ln+:2] === 2'h2)
                return;
            if (!up && tx_valid[ln] === 1'b1 && (!sync || tx_sym[8*ln+:8] === plt_pkg::SYM_K28_5))
                return;
        end
        num_errors++;
        end_sim();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rreg(plt_pkg::REG_CTRL_OFS, plt_pkg::CTRL_RESET);
        wreg(plt_pkg::REG_CTRL_OFS, 32'hFFFFF602);
        rreg(plt_pkg::REG_CTRL_OFS, 32'hDDDD0602);
        wreg(12'h100, 32'h0);
        rreg(12'h100, 32'h0);
        rreg(plt_pkg::REG_CTRL_OFS, 32'hDDDD0602);
        @(posedge clk);
        ee_load <= 1'b1;
        ee_data <= 32'hF000F602;
        @(posedge clk);
        ee_load <= 1'b0;
        rreg(plt_pkg::REG_CTRL_OFS, 32'hD0000602);
        $display("t_regs done");
    endtask
    task automatic t_skip();
        int k;
        int n;
        int c0;
        wreg(plt_pkg::REG_CTRL_OFS, 32'h0000049C);
        sym_tick <= 1'b1;
        n = 0;
        for (k = 0; k < 2600 && n < 2; k++)
        begin
            step();
            if (skip_req === 1'b1)
            begin
                if (n == 1)
                    check(k - c0, plt_pkg::SKIP_MIN);
                c0 = k;
                n++;
            end
        end
        check(n, 2);
        wreg(plt_pkg::REG_CTRL_OFS, 32'h0);
        repeat (8) step();
        n = 0;
        for (k = 0; k < 40; k++)
        begin
            step();
            n += (skip_req !== 1'b0);
        end
        check(n, 0);
        @(posedge clk);
        sym_tick <= 1'b0;
        $display("t_skip done");
    endtask
    // Lane 1 stands for port 2, lane 2 for the SuperSpeed link
    task automatic t_disable();
        int ln;
        step();
        check(rx_detect_en, 3'h7);
        wreg(plt_pkg::REG_CTRL_OFS, 32'h000D049C);
        step();
        step();
        check(rx_detect_en, 3'h0);
        check(link_state, 6'h0);
        wreg(plt_pkg::REG_CTRL_OFS, plt_pkg::CTRL_RESET);
        partner_seen <= 3'h7;
        for (ln = 0; ln < 3; ln++)
            wait_lane(ln, 1'b1, 1'b0);
        for (ln = 0; ln < 3; ln++)
        begin
            wreg(plt_pkg::REG_CTRL_OFS, 32'h49C | (32'h1 << (16 + ln + (ln > 0))));
            step();
            step();
            check(link_state, 6'h2A & ~(6'h3 << (2 * ln)));
            check(pwr_state[2*ln+:2], plt_pkg::PWR_P1);
            check(rx_detect_en[ln], 1'b0);
            check(eios_send, 3'h0);
            wreg(plt_pkg::REG_CTRL_OFS, plt_pkg::CTRL_RESET);
            wait_lane(ln, 1'b1, 1'b0);
        end
        $display("t_disable done");
    endtask
    task automatic t_quiet();
        wreg(plt_pkg::REG_CTRL_OFS, 32'h0D00049C);
        step();
        check(rate_5g, 3'h0);
        wreg(plt_pkg::REG_CTRL_OFS, 32'h0DDD049C);
        wreg(plt_pkg::REG_CTRL_OFS, 32'h0DD0049C);
        step();
        step();
        check(link_state, 6'h0);
        check(pwr_state, 6'h0);
        check(rx_term_en, 3'h7);
        check(rate_5g, 3'h7);
        rreg(plt_pkg::REG_STAT_OFS, 32'h00606060);
        $display("t_quiet done");
    endtask
    task automatic t_pattern(input int ln, input bit byp);
        logic [7:0] e [9];
        int j;
        e = '{plt_pkg::SYM_D3_2, plt_pkg::SYM_D18_2, plt_pkg::SYM_D13_2, plt_pkg::SYM_D17_1,
            plt_pkg::SYM_K28_5, plt_pkg::SYM_D3_2, plt_pkg::SYM_D18_2, plt_pkg::SYM_D13_2, 8'h5A};
        wreg(plt_pkg::REG_CTRL_OFS,
            32'h00D0049C | (32'(byp) << (28 + ln + (ln > 0))));
        user_sym[8*ln+:8] <= 8'h5A;
        pattern_en[ln] <= 1'b1;
        wait_lane(ln, 1'b0, 1'b0);
        for (j = 0; j < (byp ? 9 : 12); j++)
        begin
            check(tx_sym[8*ln+:8], byp ? e[j] : e[j%4]);
            step();
        end
        if (!byp)
        begin
            @(posedge clk);
            align_seen[ln] <= 1'b1;
            wait_lane(ln, 1'b0, 1'b1);
            for (j = 4; j < 9; j++)
            begin
                check(tx_sym[8*ln+:8], e[j]);
                step();
            end
        end
        @(posedge clk);
        pattern_en[ln] <= 1'b0;
        align_seen[ln] <= 1'b0;
        $display("t_pattern done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_skip();
        t_disable();
        t_quiet();
        t_pattern(0, 1'b1);
        t_pattern(1, 1'b0);
        t_pattern(2, 1'b1);
        end_sim();
    end
endmodule
